// >>> bench/rxcs_bench.sv
// rxcs_bench: self-checking bench for the receive command sequencer
`default_nettype none
module rxcs_bench import rxcs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, active_phase_config;
  logic [31:0] pwdata, prdata, r;
  logic        spi_enable, spi_sclk_in, spi_data_in, spi_sclk_out, spi_sclk_oe_n, spi_data_out, spi_data_oe_n;
  logic        mcu_sclk, mcu_data, rx_chip_clk, rx_slicer_data, rx_data_clk, rx_data_bit;
  logic        poll_timer_start, wakeup_done, wakeup_found, preamble_done, preamble_found, tx_command, rx_power_off;
  logic        lo_start, vco_cal_start, nmi_pulse;
  logic [1:0]  device_operating_mode, band_select;
  logic [3:0]  receive_flags;
  int          mismatches, total_checks, lo_seen, cal_seen, nmi_seen;
  // pin levels resolved from both parties' drivers
  assign spi_sclk_in = spi_sclk_oe_n ? mcu_sclk : spi_sclk_out;
  assign spi_data_in = spi_data_oe_n ? mcu_data : spi_data_out;
  rxcs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .spi_enable, .spi_sclk_in, .spi_data_in, .spi_sclk_out, .spi_sclk_oe_n, .spi_data_out, .spi_data_oe_n,
    .rx_chip_clk, .rx_slicer_data, .rx_data_clk, .rx_data_bit, .poll_timer_start, .wakeup_done,
    .wakeup_found, .preamble_done, .preamble_found, .tx_command, .rx_power_off, .device_operating_mode,
    .band_select, .lo_start, .vco_cal_start, .receive_flags, .active_phase_config, .nmi_pulse);
  rxcs_mcu u_mcu (.pclk, .spi_enable, .mcu_sclk, .mcu_data);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (lo_start === 1'b1) lo_seen++;
    if (vco_cal_start === 1'b1) cal_seen++;
    if (nmi_pulse === 1'b1) nmi_seen++;
  end
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, r, e);
    chk(r & mask, exp);
    chk(e, 1'b0);
  endtask
  // one-cycle event: {poll, wakeup done, found, preamble done, found, tx}
  task automatic ev(input logic [5:0] v);
    {poll_timer_start, wakeup_done, wakeup_found, preamble_done, preamble_found, tx_command} <= v;
    @(posedge pclk);
    {poll_timer_start, wakeup_done, wakeup_found, preamble_done, preamble_found, tx_command} <= 6'h00;
    repeat (6) @(posedge pclk);
  endtask
  // activation edge, then data driver at once and clock driver after the delay
  task automatic hand(input int dly);
    int n;
    int dn;
    n = 0;
    dn = 0;
    u_mcu.activate();
    while (spi_sclk_oe_n !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
      if (spi_data_oe_n === 1'b0 && dn == 0) dn = n;
    end
    chk(32'(dn > 0 && n - dn >= dly + 1 && n - dn <= dly + 2), 32'h1);
  endtask
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_chip_clk, rx_slicer_data, rx_data_clk, rx_data_bit, rx_power_off} = '0;
    {poll_timer_start, wakeup_done, wakeup_found, preamble_done, preamble_found, tx_command} = '0;
    {mismatches, total_checks, lo_seen, cal_seen, nmi_seen} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk({spi_sclk_out, spi_sclk_oe_n, spi_data_oe_n, spi_data_out, device_operating_mode}, 6'h38);
    rdchk(ADDR_CONTROL, 32'h3ff, 32'h200);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1'b1);
    wr(ADDR_CONTROL, 32'h1f);
    rdchk(ADDR_CONTROL, 32'h3ff, 32'hf);
    wr(ADDR_CONTROL, 32'h3);
    wr(ADDR_FOLLOWUP, 32'h21);
    wr(ADDR_PHASECFG0, 32'ha1);
    wr(ADDR_PHASECFG1, 32'hb2);
    wr(ADDR_PHASECFG2, 32'hc3);
    u_mcu.send(8'ha0, 4);
    settle();
    chk(device_operating_mode, MODE_RX);
    chk(band_select, 2'h2);
    chk(32'(lo_seen), 32'h1);
    rdchk(ADDR_STATUS, 32'h7, RXCS_IDLE);
    u_mcu.stop();
    u_mcu.send(8'h94, 8);
    settle();
    chk(receive_flags, {SUB_WAKEUP, 2'h0});
    chk(spi_data_oe_n, 1'b1);
    rdchk(ADDR_STATUS, 32'h7, RXCS_IDLE);
    hand(3);
    rdchk(ADDR_STATUS, 32'h7, RXCS_WAKEUP);
    chk({spi_sclk_out, spi_data_out, active_phase_config}, {2'b10, 8'ha1});
    chk(32'(cal_seen), 32'h0);
    ev(6'h18);
    rdchk(ADDR_STATUS, 32'h7, RXCS_DATA);
    chk({active_phase_config, 8'(nmi_seen)}, 16'hc300);
    {rx_data_clk, rx_data_bit} <= 2'b10;
    settle();
    chk({spi_sclk_out, spi_data_out}, 2'b10);
    {rx_data_clk, rx_data_bit} <= 2'b01;
    settle();
    chk({spi_sclk_out, spi_data_out}, 2'b01);
    ev(6'h20);
    rdchk(ADDR_STATUS, 32'h7, RXCS_DATA);
    ev(6'h01);
    rdchk(ADDR_STATUS, 32'h7, RXCS_IDLE);
    u_mcu.stop();
    ev(6'h20);
    rdchk(ADDR_STATUS, 32'h7, RXCS_WAKEUP);
    ev(6'h18);
    rdchk(ADDR_STATUS, 32'h7, RXCS_STOP);
    chk(32'(nmi_seen), 32'h1);
    wr(ADDR_CONTROL, 32'h103);
    u_mcu.send(8'h90, 8);
    hand(3);
    rdchk(ADDR_STATUS, 32'h7, RXCS_STOP);
    {rx_chip_clk, rx_slicer_data} <= 2'b10;
    settle();
    chk({spi_sclk_out, spi_data_out}, 2'b10);
    {rx_chip_clk, rx_slicer_data} <= 2'b01;
    settle();
    chk({spi_sclk_out, spi_data_out}, 2'b01);
    u_mcu.stop();
    wr(ADDR_CONTROL, 32'h20f);
    u_mcu.send(8'ha8, 8);
    hand(15);
    chk(32'(cal_seen), 32'h1);
    rdchk(ADDR_STATUS, 32'h7, RXCS_PREAMBLE);
    chk({spi_sclk_out, active_phase_config}, {1'b1, 8'hb2});
    ev(6'h06);
    rdchk(ADDR_STATUS, 32'h7, RXCS_DATA);
    chk(active_phase_config, 8'hc3);
    u_mcu.stop();
    wr(ADDR_CONTROL, 32'h200);
    u_mcu.send(8'hac, 8);
    hand(0);
    rdchk(ADDR_STATUS, 32'h7, RXCS_DATA);
    chk(32'(cal_seen), 32'h1);
    u_mcu.stop();
    rx_power_off <= 1'b1;
    @(posedge pclk);
    rx_power_off <= 1'b0;
    rdchk(ADDR_STATUS, 32'h7, RXCS_IDLE);
    // timer success goes to preamble, both failures stop
    wr(ADDR_FOLLOWUP, 32'h87);
    ev(6'h20);
    rdchk(ADDR_STATUS, 32'h7, RXCS_WAKEUP);
    ev(6'h18);
    rdchk(ADDR_STATUS, 32'h7, RXCS_PREAMBLE);
    chk(32'(nmi_seen), 32'h1);
    ev(6'h04);
    rdchk(ADDR_STATUS, 32'h7, RXCS_STOP);
    chk(32'(nmi_seen), 32'h2);
    ev(6'h20);
    ev(6'h10);
    rdchk(ADDR_STATUS, 32'h7, RXCS_STOP);
    chk(32'(nmi_seen), 32'h3);
    give_verdict();
  end
  // the whole sequence needs well under 100 us
  initial begin
    #1000000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> bench/rxcs_mcu.sv
// rxcs_mcu: controller model driving the three-wire serial control port
`default_nettype none
module rxcs_mcu (
  input  wire logic pclk,
  output logic      spi_enable,
  output logic      mcu_sclk,
  output logic      mcu_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv;
  initial begin
    spi_enable = 1'b0;
    mcu_sclk = 1'b0;
    mcu_data = 1'b0;
    drv = 1'b0;
  end
  // released data line wanders so a stale level is never taken for a drive
  always @(posedge pclk) begin
    if (!drv) mcu_data <= ~mcu_data;
  end
  // 200 ns step, one third of the 600 ns serial bit period
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask
  // msb first, sampled by the device on the falling edge
  task automatic send(input logic [7:0] cmd, input int nbits);
    spi_enable <= 1'b1;
    drv <= 1'b1;
    for (int i = 0; i < nbits; i++) begin
      half();
      mcu_data <= cmd[7-i];
      half();
      mcu_sclk <= 1'b1;
      half();
      mcu_sclk <= 1'b0;
    end
    half();
    drv <= 1'b0;
  endtask
  task automatic activate();
    half();
    mcu_sclk <= 1'b1;
  endtask
  // clock stands low between frames
  task automatic stop();
    half();
    spi_enable <= 1'b0;
    mcu_sclk <= 1'b0;
    // enable stays low long enough for the device to see the frame end
    half();
  endtask
endmodule
`default_nettype wire

// >>> design/rxcs_pkg.sv
// rxcs_pkg: constants and types for the receive command sequencer
`default_nettype none
package rxcs_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam logic [1:0]  MODE_RX         = 2'h2;
  localparam logic [1:0]  MODE_IDLE       = 2'h0;
  localparam logic [1:0]  CMD_PREFIX      = 2'h2;  // first bit 1, second 0, msb first
  localparam logic [1:0]  SUB_RESUME      = 2'h0;
  localparam logic [1:0]  SUB_WAKEUP      = 2'h1;
  localparam logic [1:0]  SUB_PREAMBLE    = 2'h2;
  localparam logic [1:0]  SUB_DATA        = 2'h3;
  localparam logic [1:0]  ACT_PDOWN       = 2'h0;
  localparam logic [1:0]  ACT_STOP        = 2'h1;
  localparam logic [1:0]  ACT_DATA        = 2'h2;
  localparam logic [1:0]  ACT_PREAMBLE    = 2'h3;
  localparam int unsigned BIT_BAND        = 4;
  localparam int unsigned BIT_FLAGS       = 8;
  localparam int unsigned EDGE_ACTIVATE   = 9;
  localparam logic [4:0]  DELAY_RESET     = 5'h00;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
  localparam logic [7:0]  ADDR_FOLLOWUP   = 8'h04;
  localparam logic [7:0]  ADDR_PHASECFG0  = 8'h08;
  localparam logic [7:0]  ADDR_PHASECFG1  = 8'h0c;
  localparam logic [7:0]  ADDR_PHASECFG2  = 8'h10;
  localparam logic [7:0]  ADDR_STATUS     = 8'h14;
  localparam int unsigned CTRL_DELAY_LSB  = 0;
  localparam int unsigned CTRL_TRANSP_BIT = 8;
  localparam int unsigned CTRL_VCOCAL_BIT = 9;
  typedef enum logic [2:0] {
    RXCS_IDLE     = 3'b000,
    RXCS_WAKEUP   = 3'b001,
    RXCS_PREAMBLE = 3'b010,
    RXCS_DATA     = 3'b011,
    RXCS_STOP     = 3'b100
  } rxcs_phase_t;
endpackage
`default_nettype wire

// >>> design/rxcs_top.sv
// rxcs_top: receive command interpreter, phase sequencer and serial line hand-over
`default_nettype none
module rxcs_top
  import rxcs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        spi_enable,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_data_in,
  output logic             spi_sclk_out,
  output logic             spi_sclk_oe_n,
  output logic             spi_data_out,
  output logic             spi_data_oe_n,
  input  wire logic        rx_chip_clk,
  input  wire logic        rx_slicer_data,
  input  wire logic        rx_data_clk,
  input  wire logic        rx_data_bit,
  input  wire logic        poll_timer_start,
  input  wire logic        wakeup_done,
  input  wire logic        wakeup_found,
  input  wire logic        preamble_done,
  input  wire logic        preamble_found,
  input  wire logic        tx_command,
  input  wire logic        rx_power_off,
  output logic      [1:0]  device_operating_mode,
  output logic      [1:0]  band_select,
  output logic             lo_start,
  output logic             vco_cal_start,
  output logic      [3:0]  receive_flags,
  output logic      [7:0]  active_phase_config,
  output logic             nmi_pulse
);
  import rxcs_pkg::*;

  // pin synchronisers; first stage read only by second
  logic [1:0] sclk_s_ff, din_s_ff, en_s_ff, cclk_s_ff, slc_s_ff, dclk_s_ff, dbit_s_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s_ff <= 2'h0; din_s_ff <= 2'h0; en_s_ff <= 2'h0; cclk_s_ff <= 2'h0;
      slc_s_ff <= 2'h0; dclk_s_ff <= 2'h0; dbit_s_ff <= 2'h0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[0], spi_sclk_in};
      din_s_ff  <= {din_s_ff[0], spi_data_in};
      en_s_ff   <= {en_s_ff[0], spi_enable};
      cclk_s_ff <= {cclk_s_ff[0], rx_chip_clk};
      slc_s_ff  <= {slc_s_ff[0], rx_slicer_data};
      dclk_s_ff <= {dclk_s_ff[0], rx_data_clk};
      dbit_s_ff <= {dbit_s_ff[0], rx_data_bit};
    end
  end
  logic sclk_d_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_d_ff <= 1'b0;
    else          sclk_d_ff <= sclk_s_ff[1];
  end
  wire sclk_rise = sclk_s_ff[1] & ~sclk_d_ff & en_s_ff[1];
  wire sclk_fall = ~sclk_s_ff[1] & sclk_d_ff & en_s_ff[1];

  // apb register file
  logic [9:0]  ctrl_ff;
  logic [7:0]  followup_ff;
  logic [7:0]  cfg_ff [3];
  wire         apb_acc  = psel & penable;
  wire         hit_ctrl = paddr == ADDR_CONTROL;
  wire         hit_fu   = paddr == ADDR_FOLLOWUP;
  wire         hit_c0   = paddr == ADDR_PHASECFG0;
  wire         hit_c1   = paddr == ADDR_PHASECFG1;
  wire         hit_c2   = paddr == ADDR_PHASECFG2;
  wire         hit_st   = paddr == ADDR_STATUS;
  wire         hit_any  = hit_ctrl | hit_fu | hit_c0 | hit_c1 | hit_c2 | hit_st;
  wire [4:0]   delay_cfg = ctrl_ff[CTRL_DELAY_LSB +: 5];
  wire         transparent = ctrl_ff[CTRL_TRANSP_BIT];
  // follow-up fields: [1:0] timer success, [2] timer fail, [5:4] cmd success,
  // [6] cmd fail (0 pdown,1 stop), [7] preamble fail (0 pdown,1 stop)
  logic [2:0]  phase_q;
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {22'h0, ctrl_ff} :
                  hit_fu   ? {24'h0, followup_ff} :
                  hit_c0   ? {24'h0, cfg_ff[0]} :
                  hit_c1   ? {24'h0, cfg_ff[1]} :
                  hit_c2   ? {24'h0, cfg_ff[2]} :
                  hit_st   ? {23'h0, receive_flags, device_operating_mode, phase_q} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= {2'h2, 3'h0, DELAY_RESET}; followup_ff <= 8'h00;
      cfg_ff[0] <= 8'h00; cfg_ff[1] <= 8'h00; cfg_ff[2] <= 8'h00;
      prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      pready  <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~hit_any;
      if (apb_acc & ~pready & ~pwrite) prdata <= rd_mux;
      if (apb_acc & pready & pwrite) begin
        if (hit_ctrl) ctrl_ff <= {pwdata[9:8], 3'h0, 1'b0, pwdata[3:0]};
        if (hit_fu)   followup_ff <= pwdata[7:0];
        if (hit_c0)   cfg_ff[0] <= pwdata[7:0];
        if (hit_c1)   cfg_ff[1] <= pwdata[7:0];
        if (hit_c2)   cfg_ff[2] <= pwdata[7:0];
      end
    end
  end

  // serial command shift
  // five bits: the activation edge is the seventeenth, and a later driven clock must not wrap
  logic [4:0] edge_cnt_ff;
  logic [7:0] shreg_ff;
  logic       is_rx_ff, seen_tx_ff, seen_rx_ff, armed_ff;
  wire  [7:0] sh_next = {shreg_ff[6:0], din_s_ff[1]};
  wire [3:0]  bit_no = 4'(edge_cnt_ff[4:1] + 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_ff <= 5'h00; shreg_ff <= 8'h00; is_rx_ff <= 1'b0;
    end else if (!en_s_ff[1]) begin
      edge_cnt_ff <= 5'h00; is_rx_ff <= 1'b0;
    end else if ((sclk_rise | sclk_fall) && edge_cnt_ff != 5'h1f) begin
      edge_cnt_ff <= 5'(edge_cnt_ff + 5'h01);
      if (sclk_fall) shreg_ff <= sh_next;
      if (sclk_fall && bit_no == 4'h2) is_rx_ff <= sh_next[1:0] == CMD_PREFIX;
    end
  end
  // bits sampled on falling edges: the nth falling edge is edge count 2n-1
  wire fall4 = sclk_fall & is_rx_ff & edge_cnt_ff == 5'(2 * BIT_BAND - 1);
  wire fall8 = sclk_fall & is_rx_ff & edge_cnt_ff == 5'(2 * BIT_FLAGS - 1);
  wire rise9 = sclk_rise & armed_ff & edge_cnt_ff == 5'(2 * BIT_FLAGS);
  wire [1:0] band_new = sh_next[1:0];
  wire       need_cal = seen_tx_ff | ~seen_rx_ff | (band_new != band_select);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_operating_mode <= MODE_IDLE; band_select <= 2'h0; lo_start <= 1'b0;
      vco_cal_start <= 1'b0; receive_flags <= 4'h0; seen_tx_ff <= 1'b0;
      seen_rx_ff <= 1'b0; armed_ff <= 1'b0;
    end else begin
      lo_start      <= fall4;
      vco_cal_start <= fall4 & need_cal & ctrl_ff[CTRL_VCOCAL_BIT];
      if (fall4) begin
        device_operating_mode <= MODE_RX;
        band_select <= band_new;
        seen_rx_ff  <= 1'b1;
        seen_tx_ff  <= 1'b0;
      end
      if (tx_command) seen_tx_ff <= 1'b1;                      // a transmit in the same cycle wins
      if (fall8) begin
        receive_flags <= sh_next[3:0];
        armed_ff <= 1'b1;
      end else if (rise9 | ~en_s_ff[1]) armed_ff <= 1'b0;
    end
  end

  // receive phase sequencer
  rxcs_phase_t phase_ff, nxt_phase;
  logic        timer_src_ff, nmi_nxt;
  wire  [1:0]  sub = receive_flags[3:2];
  assign phase_q = phase_ff;
  always_comb begin
    nxt_phase = phase_ff;
    nmi_nxt   = 1'b0;
    if (tx_command | rx_power_off) nxt_phase = RXCS_IDLE;
    else if (rise9) begin
      case (sub)
        SUB_WAKEUP:   nxt_phase = RXCS_WAKEUP;
        SUB_PREAMBLE: nxt_phase = RXCS_PREAMBLE;
        SUB_DATA:     nxt_phase = RXCS_DATA;
        default:      nxt_phase = phase_ff;
      endcase
    end else if (poll_timer_start && phase_ff != RXCS_DATA) nxt_phase = RXCS_WAKEUP;
    else begin
      case (phase_ff)
        RXCS_WAKEUP: if (wakeup_done) begin
          if (wakeup_found) begin
            case (timer_src_ff ? followup_ff[1:0] : followup_ff[5:4])
              ACT_DATA:     nxt_phase = RXCS_DATA;
              ACT_PREAMBLE: nxt_phase = RXCS_PREAMBLE;
              default:      nxt_phase = RXCS_STOP;
            endcase
          end else if (timer_src_ff ? followup_ff[2] : followup_ff[6]) nxt_phase = RXCS_STOP;
          else nxt_phase = RXCS_IDLE;
          nmi_nxt = timer_src_ff & (nxt_phase == RXCS_STOP | nxt_phase == RXCS_DATA);
        end
        RXCS_PREAMBLE: if (preamble_done) begin
          if (preamble_found) nxt_phase = RXCS_DATA;
          else if (followup_ff[7]) nxt_phase = RXCS_STOP;
          else nxt_phase = RXCS_IDLE;
          nmi_nxt = timer_src_ff & (nxt_phase == RXCS_DATA | nxt_phase == RXCS_STOP);
        end
        default: nxt_phase = phase_ff;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= RXCS_IDLE; timer_src_ff <= 1'b0; nmi_pulse <= 1'b0; active_phase_config <= 8'h00;
    end else begin
      phase_ff  <= nxt_phase;
      nmi_pulse <= nmi_nxt;
      if (rise9) timer_src_ff <= 1'b0;
      else if (poll_timer_start && phase_ff != RXCS_DATA) timer_src_ff <= 1'b1;
      // wakeup, preamble and data each load their own set: wakeup cfg_ff[0], preamble cfg_ff[1], data cfg_ff[2]; idle and stop hold it
      case (nxt_phase)
        RXCS_WAKEUP:   active_phase_config <= cfg_ff[0];
        RXCS_PREAMBLE: active_phase_config <= cfg_ff[1];
        RXCS_DATA:     active_phase_config <= cfg_ff[2];
        default:       active_phase_config <= active_phase_config;
      endcase
    end
  end

  // line hand-over; reference clock is pclk, so the ninth rising edge event is already resynchronised
  logic       handed_ff, clk_on_ff;
  logic [4:0] dly_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      handed_ff <= 1'b0; clk_on_ff <= 1'b0; dly_ff <= 5'h0;
    end else if (!en_s_ff[1] | tx_command) begin
      handed_ff <= 1'b0; clk_on_ff <= 1'b0;
    end else if (rise9) begin
      handed_ff <= 1'b1; clk_on_ff <= 1'b0; dly_ff <= delay_cfg;
    end else if (handed_ff & ~clk_on_ff) begin
      if (dly_ff == 5'h0) clk_on_ff <= 1'b1;
      else dly_ff <= 5'(dly_ff - 5'h1);
    end
  end
  wire in_data = phase_ff == RXCS_DATA;
  wire clk_val = transparent ? cclk_s_ff[1] : (in_data ? dclk_s_ff[1] : 1'b1);
  wire dat_val = transparent ? slc_s_ff[1] :
                 in_data ? dbit_s_ff[1] : (phase_ff != RXCS_WAKEUP);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_sclk_out <= 1'b1; spi_sclk_oe_n <= 1'b1; spi_data_out <= 1'b0; spi_data_oe_n <= 1'b1;
    end else begin
      spi_sclk_out  <= clk_val;
      spi_sclk_oe_n <= ~(handed_ff & clk_on_ff);
      spi_data_out  <= dat_val;
      spi_data_oe_n <= ~(handed_ff | rise9);
    end
  end

  property p_mode_rx;
    @(posedge pclk) disable iff (!presetn) fall4 |=> device_operating_mode == MODE_RX;
  endproperty
  a_mode_rx: assert property (p_mode_rx) else $error("receive mode not entered");
  property p_flags;
    @(posedge pclk) disable iff (!presetn) fall8 |=> receive_flags == $past(sh_next[3:0]) && phase_ff == $past(phase_ff);
  endproperty
  a_flags: assert property (p_flags) else $error("flag latch wrong");
  property p_start;
    @(posedge pclk) disable iff (!presetn) rise9 && sub == SUB_WAKEUP && !tx_command && !rx_power_off |=> phase_ff == RXCS_WAKEUP;
  endproperty
  a_start: assert property (p_start) else $error("wakeup not started");
  property p_delay;
    @(posedge pclk) disable iff (!presetn) rise9 && en_s_ff[1] && !tx_command ##1 (en_s_ff[1] && !tx_command)[*2] |-> spi_sclk_oe_n;
  endproperty
  a_delay: assert property (p_delay) else $error("clock driver too early");
  property p_data_now;
    @(posedge pclk) disable iff (!presetn) rise9 && en_s_ff[1] && !tx_command |=> !spi_data_oe_n;
  endproperty
  a_data_now: assert property (p_data_now) else $error("data not routed");
  property p_clk_high;
    @(posedge pclk) disable iff (!presetn) !transparent && phase_ff == RXCS_WAKEUP |=> spi_sclk_out;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock not high");
  property p_data_low;
    @(posedge pclk) disable iff (!presetn) !transparent && phase_ff == RXCS_WAKEUP |=> !spi_data_out;
  endproperty
  a_data_low: assert property (p_data_low) else $error("data not low");
  property p_cfg;
    @(posedge pclk) disable iff (!presetn) nxt_phase == RXCS_DATA |=> active_phase_config == $past(cfg_ff[2]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("wrong phase set");
  property p_nmi;
    @(posedge pclk) disable iff (!presetn) nmi_pulse |-> $past(timer_src_ff) && phase_ff inside {RXCS_DATA, RXCS_STOP};
  endproperty
  a_nmi: assert property (p_nmi) else $error("stray interrupt");
  property p_end;
    @(posedge pclk) disable iff (!presetn) tx_command |=> phase_ff == RXCS_IDLE;
  endproperty
  a_end: assert property (p_end) else $error("reception not ended");
endmodule
`default_nettype wire
